// File: fsi_pkg.sv
// shared constants and helpers for the fifo status and interrupt block
package fsi_pkg;

  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned LEVEL_W    = 5;
  localparam int unsigned ADDR_W     = 3;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned COND_W     = 6;
  localparam int unsigned MASK_W     = 7;

  // register indices, one 32-bit word each
  localparam logic [ADDR_W-1:0] REG_FILL_LEVEL  = 3'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS      = 3'h1;
  localparam logic [ADDR_W-1:0] REG_EVENT       = 3'h2;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK    = 3'h3;
  localparam logic [ADDR_W-1:0] REG_NEAR_FULL   = 3'h4;
  localparam logic [ADDR_W-1:0] REG_NEAR_EMPTY  = 3'h5;

  // condition bit positions, shared by status, event and mask; BIT_ALL is a mask bit only
  localparam int unsigned BIT_EMPTY      = 0;
  localparam int unsigned BIT_FULL       = 1;
  localparam int unsigned BIT_NEAR_EMPTY = 2;
  localparam int unsigned BIT_NEAR_FULL  = 3;
  localparam int unsigned BIT_OVERFLOW   = 4;
  localparam int unsigned BIT_UNDERFLOW  = 5;
  localparam int unsigned BIT_ALL        = 6;

  localparam logic [LEVEL_W-1:0] DEPTH_LEVEL     = 5'h10;
  localparam logic [LEVEL_W-1:0] NEAR_FULL_MAX   = 5'h0f;
  localparam logic [LEVEL_W-1:0] NEAR_FULL_RST   = 5'h0f;
  localparam logic [LEVEL_W-1:0] NEAR_EMPTY_RST  = 5'h01;
  localparam logic [LEVEL_W-1:0] THRESH_MIN      = 5'h01;
  localparam logic [MASK_W-1:0]  IRQ_MASK_RST    = 7'h00;
  localparam logic [COND_W-1:0]  EVENT_RST       = 6'h00;

  // clamp a written threshold into [THRESH_MIN, limit]
  function automatic logic [LEVEL_W-1:0] fsi_clamp(input logic [DATA_W-1:0] val,
                                                   input logic [LEVEL_W-1:0] limit);
    logic [LEVEL_W-1:0] res;
    res = val[LEVEL_W-1:0];
    if (val < {{(DATA_W-LEVEL_W){1'b0}}, THRESH_MIN}) begin
      res = THRESH_MIN;
    end else if (val > {{(DATA_W-LEVEL_W){1'b0}}, limit}) begin
      res = limit;
    end
    return res;
  endfunction

endpackage

// File: fsi_event_bits.sv
// sticky event bits with write-one-to-clear
`timescale 1ns/10ps
module fsi_event_bits (
  input  wire logic                       core_clk,  // block clock
  input  wire logic                       reset,     // async, active high
  input  wire logic [fsi_pkg::COND_W-1:0] set_in,    // instantaneous status
  input  wire logic [fsi_pkg::COND_W-1:0] clr_in,    // one-to-clear strobe
  output logic      [fsi_pkg::COND_W-1:0] event_q    // sticky events
);
  import fsi_pkg::*;

  genvar i;
  generate
    for (i = 0; i < COND_W; i++) begin : g_bit
      // set wins over a clear in the same cycle so no event is lost
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          event_q[i] <= EVENT_RST[i];
        end else if (set_in[i]) begin
          event_q[i] <= 1'b1;
        end else if (clr_in[i]) begin
          event_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// File: fsi_status_irq.sv
// fifo status registers, threshold compare and interrupt generation
`timescale 1ns/10ps
module fsi_status_irq (
  input  wire logic                        core_clk,        // block clock, 100 MHz
  input  wire logic                        reset,           // async, active high
  input  wire logic [fsi_pkg::LEVEL_W-1:0] fill_level,      // fifo entries held
  input  wire logic                        push_attempt,    // input master writes
  input  wire logic                        pop_attempt,     // output master reads
  input  wire logic                        backpressure_on, // build has backpressure
  input  wire logic [fsi_pkg::ADDR_W-1:0]  csr_address,     // word index
  input  wire logic                        csr_read,        // read strobe
  input  wire logic                        csr_write,       // write strobe
  input  wire logic [fsi_pkg::DATA_W-1:0]  csr_writedata,   // write data
  output logic      [fsi_pkg::DATA_W-1:0]  csr_readdata,    // read data, registered
  output logic                             csr_readvalid,   // read data valid pulse
  output logic                             irq              // interrupt, level
);
  import fsi_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // register state

  logic [MASK_W-1:0]  irq_mask_q;
  logic [LEVEL_W-1:0] near_full_q;
  logic [LEVEL_W-1:0] near_empty_q;
  logic [DATA_W-1:0]  rdata_q;
  logic [DATA_W-1:0]  rdata_d;
  logic               rvalid_q;
  logic [COND_W-1:0]  event_q;

  //////////////////////////////////////////////////////////////////////////
  // condition detection

  wire is_full       = (fill_level == DEPTH_LEVEL);
  wire is_empty      = (fill_level == '0);
  wire full_cond     = is_full;
  wire empty_cond    = is_empty;
  wire near_full_c   = (fill_level > near_full_q);
  wire near_empty_c  = (fill_level < near_empty_q);
  // one cycle per attempt; masked off when backpressure blocks the access
  wire overflow_c    = push_attempt & is_full & ~backpressure_on;
  wire underflow_c   = pop_attempt & is_empty & ~backpressure_on;

  wire [COND_W-1:0] status_now;
  assign status_now[BIT_EMPTY]      = empty_cond;
  assign status_now[BIT_FULL]       = full_cond;
  assign status_now[BIT_NEAR_EMPTY] = near_empty_c;
  assign status_now[BIT_NEAR_FULL]  = near_full_c;
  assign status_now[BIT_OVERFLOW]   = overflow_c;
  assign status_now[BIT_UNDERFLOW]  = underflow_c;

  //////////////////////////////////////////////////////////////////////////
  // register decode

  wire wr_mask  = csr_write & (csr_address == REG_IRQ_MASK);
  wire wr_event = csr_write & (csr_address == REG_EVENT);
  wire wr_nf    = csr_write & (csr_address == REG_NEAR_FULL);
  wire wr_ne    = csr_write & (csr_address == REG_NEAR_EMPTY);

  wire [COND_W-1:0]  event_clr = wr_event ? csr_writedata[COND_W-1:0] : '0;
  wire [LEVEL_W-1:0] nf_clamp  = fsi_clamp(csr_writedata, NEAR_FULL_MAX);
  wire [LEVEL_W-1:0] ne_clamp  = fsi_clamp(csr_writedata, NEAR_FULL_MAX);

  fsi_event_bits u_events (
    .core_clk (core_clk),
    .reset    (reset),
    .set_in   (status_now),
    .clr_in   (event_clr),
    .event_q  (event_q)
  );

  //////////////////////////////////////////////////////////////////////////
  // writable registers

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_q <= csr_writedata[MASK_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      near_full_q <= NEAR_FULL_RST;
    end else if (wr_nf) begin
      near_full_q <= nf_clamp;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      near_empty_q <= NEAR_EMPTY_RST;
    end else if (wr_ne) begin
      near_empty_q <= ne_clamp;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read path, one cycle latency

  always_comb begin
    rdata_d = '0;
    unique case (csr_address)
      REG_FILL_LEVEL: rdata_d = {{(DATA_W-LEVEL_W){1'b0}}, fill_level};
      REG_STATUS:     rdata_d = {{(DATA_W-COND_W){1'b0}}, status_now};
      REG_EVENT:      rdata_d = {{(DATA_W-COND_W){1'b0}}, event_q};
      REG_IRQ_MASK:   rdata_d = {{(DATA_W-MASK_W){1'b0}}, irq_mask_q};
      REG_NEAR_FULL:  rdata_d = {{(DATA_W-LEVEL_W){1'b0}}, near_full_q};
      REG_NEAR_EMPTY: rdata_d = {{(DATA_W-LEVEL_W){1'b0}}, near_empty_q};
      default:        rdata_d = '0;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= csr_read ? rdata_d : '0;
      rvalid_q <= csr_read;
    end
  end

  assign csr_readdata  = rdata_q;
  assign csr_readvalid = rvalid_q;

  //////////////////////////////////////////////////////////////////////////
  // interrupt

  // global bit widens every per-condition enable
  wire [COND_W-1:0] eff_enable = irq_mask_q[COND_W-1:0] | {COND_W{irq_mask_q[BIT_ALL]}};
  // level output: a rising sticky bit that is enabled raises it, clearing the bits drops it
  assign irq = |(event_q & eff_enable);

endmodule

// File: fsi_status_irq_properties.sv
// port assertions for the fifo status block
`timescale 1ns/10ps
module fsi_status_irq_chk import fsi_pkg::*; (
  input wire logic        core_clk,      // clock
  input wire logic        reset,         // reset
  input wire logic [4:0]  fill_level,    // level
  input wire logic [2:0]  csr_address,   // index
  input wire logic        csr_read,      // read
  input wire logic        csr_write,     // write
  input wire logic [31:0] csr_writedata, // wdata
  input wire logic [31:0] csr_readdata,  // rdata
  input wire logic        csr_readvalid, // valid
  input wire logic        irq            // irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire clr = csr_write && (csr_address == REG_EVENT || csr_address == REG_IRQ_MASK);
  sequence s_en(int b); csr_write && csr_address == REG_IRQ_MASK && csr_writedata[b]; endsequence
  property p_en(int b, logic c); s_en(b) ##0 c |=> irq; endproperty
  chk_read_answer: assert property (csr_read |=> csr_readvalid) else $error("no read answer");
  chk_idle_zero: assert property (!csr_readvalid |-> csr_readdata == '0) else $error("idle data");
  chk_full_irq: assert property (p_en(BIT_FULL, fill_level == DEPTH_LEVEL)) else $error("full");
  chk_empty_irq: assert property (p_en(BIT_EMPTY, fill_level == 5'h00)) else $error("empty");
  chk_nfull_irq: assert property (p_en(BIT_NEAR_FULL, fill_level == DEPTH_LEVEL)) else $error("nfull");
  chk_nempty_irq: assert property (p_en(BIT_NEAR_EMPTY, fill_level == 5'h00)) else $error("nempty");
  chk_all_irq: assert property (p_en(BIT_ALL, fill_level == 5'h00)) else $error("all");
  chk_irq_hold: assert property (irq && !clr |=> irq) else $error("irq dropped");
endmodule
bind fsi_status_irq fsi_status_irq_chk u_chk (.core_clk(core_clk), .reset(reset), .fill_level(fill_level),
  .csr_address(csr_address), .csr_read(csr_read), .csr_write(csr_write), .csr_writedata(csr_writedata),
  .csr_readdata(csr_readdata), .csr_readvalid(csr_readvalid), .irq(irq));

// File: fsi_master_model.sv
// status master model for single-word register access
`timescale 1ns/10ps
module fsi_master_model (
  input  wire logic        core_clk, // clock
  input  wire logic [31:0] rdata,    // read data
  output logic      [2:0]  addr,     // index
  output logic             rd,       // read
  output logic             wr,       // write
  output logic      [31:0] wdata     // write data
);
  initial {addr, wdata, rd, wr} = '0;
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    {addr, wdata, wr, rd} <= {a, d, w, !w};
    @(posedge core_clk);
    {addr, wdata, wr, rd} <= {~a, ~d, 2'b00};
    // read data stands for the cycle after the request edge; take it mid-cycle
    @(negedge core_clk);
    q = rdata;
  endtask
endmodule

// File: fsi_status_irq_tb.sv
// self-checking bench for the fifo status block
`timescale 1ns/10ps
module fsi_status_irq_tb;
  import fsi_pkg::*;
  logic               core_clk = 1'b0, reset = 1'b1, push = 1'b0, pop = 1'b0, bp = 1'b0, rd, wr, irq, rvalid;
  logic [LEVEL_W-1:0] fill = 5'h08;
  logic [ADDR_W-1:0]  addr;
  logic [DATA_W-1:0]  wdata, rdata, d, ev;
  int                 n_errors = 0, total_checks = 0;
  fsi_status_irq dut (.core_clk(core_clk), .reset(reset), .fill_level(fill), .push_attempt(push),
    .pop_attempt(pop), .backpressure_on(bp), .csr_address(addr), .csr_read(rd), .csr_write(wr),
    .csr_writedata(wdata), .csr_readdata(rdata), .csr_readvalid(rvalid), .irq(irq));
  fsi_master_model m (.core_clk(core_clk), .rdata(rdata), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata));
  initial forever #5 core_clk = ~core_clk;
  initial #20us final_report(1);
  task automatic chk(input string n, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) n_errors++;
    if (got !== exp) $display("[ERR] %s exp %h got %h", n, exp, got);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [31:0] exp);
    m.bus(1'b0, a, 32'h0, d);
    chk($sformatf("reg %0d", a), d, exp);
    chk("read valid", {31'h0, rvalid}, 32'h1);
  endtask
  task automatic t_regs;
    rchk(REG_IRQ_MASK, 32'h0);
    m.bus(1'b1, REG_IRQ_MASK, 32'hffffffff, d);
    rchk(REG_IRQ_MASK, 32'h7f);
    m.bus(1'b1, REG_NEAR_FULL, 32'h07, d);
    rchk(REG_NEAR_FULL, 32'h07);
    m.bus(1'b1, REG_NEAR_FULL, 32'h20, d);
    rchk(REG_NEAR_FULL, 32'h0f);
    m.bus(1'b1, REG_NEAR_EMPTY, 32'h0c, d);
    rchk(REG_NEAR_EMPTY, 32'h0c);
    m.bus(1'b1, REG_NEAR_EMPTY, 32'h40, d);
    rchk(REG_NEAR_EMPTY, 32'h0f);
    m.bus(1'b1, REG_NEAR_EMPTY, 32'h0, d);
    rchk(REG_NEAR_EMPTY, 32'h01);
  endtask
  // live status: overflow and underflow only while an attempt meets full or empty
  task automatic t_status;
    @(posedge core_clk);
    {fill, push, bp} <= {DEPTH_LEVEL, 1'b1, 1'b0};
    rchk(REG_STATUS, 32'h1a);
    rchk(REG_FILL_LEVEL, 32'h10);
    @(posedge core_clk);
    bp <= 1'b1;
    rchk(REG_STATUS, 32'h0a);
    @(posedge core_clk);
    {fill, push, pop, bp} <= {5'h00, 1'b0, 1'b1, 1'b0};
    rchk(REG_STATUS, 32'h25);
    @(posedge core_clk);
    pop <= 1'b0;
    rchk(REG_STATUS, 32'h05);
  endtask
  // second reset in mid-run: irq is low and the mask and threshold registers return to their reset values
  task automatic t_reset;
    @(posedge core_clk);
    {reset, fill} <= {1'b1, 5'h08};
    repeat (2) @(posedge core_clk);
    chk("irq reset", {31'h0, irq}, 32'h0);
    reset <= 1'b0;
    rchk(REG_IRQ_MASK, {25'h0, IRQ_MASK_RST});
    rchk(REG_NEAR_FULL, {27'h0, NEAR_FULL_RST});
    rchk(REG_NEAR_EMPTY, {27'h0, NEAR_EMPTY_RST});
  endtask
  task automatic t_irq;
    for (int b = 0; b < 7; b++) begin
      ev = (b == 1 || b == 3 || b == 4) ? 32'h0a : 32'h05;
      ev[5:4] = {b == 5, b == 4};
      @(posedge core_clk);
      fill <= 5'h08;
      m.bus(1'b1, REG_EVENT, 32'h3f, d);
      chk("irq idle", {31'h0, irq}, 32'h0);
      @(posedge core_clk);
      {fill, push, pop} <= {ev[1] ? DEPTH_LEVEL : 5'h00, ev[4], ev[5]};
      @(posedge core_clk);
      {push, pop} <= 2'b00;
      m.bus(1'b1, REG_IRQ_MASK, 32'h1 << b, d);
      chk("irq set", {31'h0, irq}, 32'h1);
      rchk(REG_EVENT, ev);
    end
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    t_regs();
    t_irq();
    t_status();
    t_reset();
    final_report(0);
  end
  task automatic final_report(input int late);
    n_errors += late;
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
endmodule
